// [rtl/sdm_cal_result_mux.sv]
`default_nettype none
`include "sdm_map.svh"
module sdm_cal_result_mux #(
	parameter int RES_BITS = 24
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// special-function register port
	input wire sdm_pkg::sdm_sfr_req_t sfr_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// converter state
	input wire logic [2:0] converter_system_mode_i,
	// filter results
	input wire sdm_pkg::sdm_result_t sinc_res_i,
	input wire sdm_pkg::sdm_result_t fast_res_i,
	// calibration engine writes
	input wire logic cal_ofs_we_i,
	input wire logic [23:0] cal_ofs_i,
	input wire logic cal_gain_we_i,
	input wire logic [23:0] cal_gain_i,
	// values to the analog side
	output logic [23:0] offset_cal_value_o,
	output logic [23:0] gain_cal_value_o,
	output sdm_pkg::sdm_src_t positive_input_o,
	output sdm_pkg::sdm_src_t negative_input_o,
	output logic temp_sensor_en_o,
	output logic mux_write_busy_o
);
	initial begin
		if (RES_BITS != 24 && RES_BITS != 16) begin
			$error("RES_BITS must be 16 or 24");
		end
	end

	logic [23:0] offset_cal_value;
	logic [23:0] gain_cal_value;
	logic [7:0] input_mux_control;
	logic [23:0] sinc_value;
	logic [23:0] fast_value;
	logic [2:0] sinc_we;
	logic [2:0] fast_we;
	logic wr;

	assign wr = sfr_i.wr;

	// offset calibration; calibration engine wins over a software write
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			offset_cal_value <= `SDM_RST_OFS;
		end else if (cal_ofs_we_i) begin
			offset_cal_value <= cal_ofs_i;
		end else if (wr) begin
			unique case (sfr_i.addr)
				`SDM_ADDR_OFS_HI: begin
					offset_cal_value[23:16] <= sfr_i.wdata;
				end
				`SDM_ADDR_OFS_MID: begin
					offset_cal_value[15:8] <= sfr_i.wdata;
				end
				`SDM_ADDR_OFS_LO: begin
					offset_cal_value[7:0] <= sfr_i.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// gain calibration
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gain_cal_value <= `SDM_RST_GAIN;
		end else if (cal_gain_we_i) begin
			gain_cal_value <= cal_gain_i;
		end else if (wr) begin
			unique case (sfr_i.addr)
				`SDM_ADDR_GAIN_HI: begin
					gain_cal_value[23:16] <= sfr_i.wdata;
				end
				`SDM_ADDR_GAIN_MID: begin
					gain_cal_value[15:8] <= sfr_i.wdata;
				end
				`SDM_ADDR_GAIN_LO: begin
					gain_cal_value[7:0] <= sfr_i.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// mux control; writes outside idle are still taken, only flagged
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			input_mux_control <= `SDM_RST_MUX;
		end else if (wr && sfr_i.addr == `SDM_ADDR_MUX) begin
			input_mux_control <= sfr_i.wdata;
		end
	end

	// hint that the last mux write came while not idle; every mux write updates it
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mux_write_busy_o <= 1'b0;
		end else if (wr && sfr_i.addr == `SDM_ADDR_MUX) begin
			mux_write_busy_o <= (converter_system_mode_i != `SDM_MODE_IDLE);
		end
	end

	always_comb begin
		sinc_we = 3'h0;
		fast_we = 3'h0;
		if (wr) begin
			sinc_we[2] = (sfr_i.addr == `SDM_ADDR_SINC_HI);
			sinc_we[1] = (sfr_i.addr == `SDM_ADDR_SINC_MID);
			sinc_we[0] = (sfr_i.addr == `SDM_ADDR_SINC_LO);
			fast_we[2] = (sfr_i.addr == `SDM_ADDR_FAST_HI);
			fast_we[1] = (sfr_i.addr == `SDM_ADDR_FAST_MID);
			fast_we[0] = (sfr_i.addr == `SDM_ADDR_FAST_LO);
		end
	end

	sdm_result_reg #(
		.RES_BITS(RES_BITS)
	) u_sinc (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.res_i(sinc_res_i),
		.byte_we_i(sinc_we),
		.wdata_i(sfr_i.wdata),
		.value_o(sinc_value)
	);

	sdm_result_reg #(
		.RES_BITS(RES_BITS)
	) u_fast (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.res_i(fast_res_i),
		.byte_we_i(fast_we),
		.wdata_i(sfr_i.wdata),
		.value_o(fast_value)
	);

	sdm_src_decode u_pos (
		.code_i(input_mux_control[`SDM_POS_MSB:`SDM_POS_LSB]),
		.src_o(positive_input_o)
	);

	sdm_src_decode u_neg (
		.code_i(input_mux_control[`SDM_NEG_MSB:`SDM_NEG_LSB]),
		.src_o(negative_input_o)
	);

	// no software enable bit exists for the sensor
	assign temp_sensor_en_o = (positive_input_o.kind == sdm_pkg::SDM_SRC_TEMP) ||
		(negative_input_o.kind == sdm_pkg::SDM_SRC_TEMP);

	assign offset_cal_value_o = offset_cal_value;
	assign gain_cal_value_o = gain_cal_value;

	// read data registered: answer one cycle after the read strobe
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sfr_rdata_o <= 8'h00;
			sfr_hit_o <= 1'b0;
		end else if (sfr_i.rd) begin
			sfr_hit_o <= 1'b1;
			unique case (sfr_i.addr)
				`SDM_ADDR_OFS_HI: sfr_rdata_o <= offset_cal_value[23:16];
				`SDM_ADDR_OFS_MID: sfr_rdata_o <= offset_cal_value[15:8];
				`SDM_ADDR_OFS_LO: sfr_rdata_o <= offset_cal_value[7:0];
				`SDM_ADDR_GAIN_HI: sfr_rdata_o <= gain_cal_value[23:16];
				`SDM_ADDR_GAIN_MID: sfr_rdata_o <= gain_cal_value[15:8];
				`SDM_ADDR_GAIN_LO: sfr_rdata_o <= gain_cal_value[7:0];
				`SDM_ADDR_SINC_HI: sfr_rdata_o <= sinc_value[23:16];
				`SDM_ADDR_SINC_MID: sfr_rdata_o <= sinc_value[15:8];
				`SDM_ADDR_SINC_LO: sfr_rdata_o <= sinc_value[7:0];
				`SDM_ADDR_FAST_HI: sfr_rdata_o <= fast_value[23:16];
				`SDM_ADDR_FAST_MID: sfr_rdata_o <= fast_value[15:8];
				`SDM_ADDR_FAST_LO: sfr_rdata_o <= fast_value[7:0];
				`SDM_ADDR_MUX: sfr_rdata_o <= input_mux_control;
				default: begin
					sfr_rdata_o <= 8'h00;
					sfr_hit_o <= 1'b0;
				end
			endcase
		end else begin
			sfr_hit_o <= 1'b0;
		end
	end
endmodule : sdm_cal_result_mux
`default_nettype wire

// [rtl/sdm_map.svh]
`ifndef SDM_MAP_SVH
`define SDM_MAP_SVH
// special-function register addresses
`define SDM_ADDR_GAIN_LO 8'hAB
`define SDM_ADDR_GAIN_MID 8'hAC
`define SDM_ADDR_GAIN_HI 8'hAD
`define SDM_ADDR_OFS_LO 8'hBA
`define SDM_ADDR_OFS_MID 8'hBB
`define SDM_ADDR_OFS_HI 8'hBC
`define SDM_ADDR_SINC_LO 8'hC3
`define SDM_ADDR_SINC_MID 8'hC4
`define SDM_ADDR_SINC_HI 8'hC5
`define SDM_ADDR_MUX 8'hC6
`define SDM_ADDR_FAST_LO 8'hFC
`define SDM_ADDR_FAST_MID 8'hFD
`define SDM_ADDR_FAST_HI 8'hFE
// reset values
`define SDM_RST_OFS 24'h000000
`define SDM_RST_GAIN 24'h000000
`define SDM_RST_MUX 8'h00
`define SDM_RST_RESULT 24'h000000
// mux field positions and codes
`define SDM_POS_MSB 7
`define SDM_POS_LSB 4
`define SDM_NEG_MSB 3
`define SDM_NEG_LSB 0
`define SDM_SEL_TEMP 4'hF
`define SDM_MODE_IDLE 3'h0
`endif

// [rtl/sdm_pkg.sv]
`default_nettype none
package sdm_pkg;
	typedef enum logic [2:0] {
		SDM_SRC_PIN = 3'h1,
		SDM_SRC_GND = 3'h2,
		SDM_SRC_TEMP = 3'h4
	} sdm_src_kind_t;

	typedef struct packed {
		sdm_src_kind_t kind;
		logic [2:0] pin;
	} sdm_src_t;

	typedef struct packed {
		logic valid;
		logic [23:0] data;
	} sdm_result_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sdm_sfr_req_t;
endpackage : sdm_pkg
`default_nettype wire

// [rtl/sdm_result_reg.sv]
`default_nettype none
`include "sdm_map.svh"
module sdm_result_reg #(
	parameter int RES_BITS = 24
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// filter result in, right aligned
	input wire sdm_pkg::sdm_result_t res_i,
	// software byte write
	input wire logic [2:0] byte_we_i,
	input wire logic [7:0] wdata_i,
	// held value, byte layout as seen by software
	output logic [23:0] value_o
);
	initial begin
		if (RES_BITS != 24 && RES_BITS != 16) begin
			$error("RES_BITS must be 16 or 24");
		end
	end

	logic [23:0] held;

	// whole result lands in one edge; a result arriving between byte reads mixes two results
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			held <= `SDM_RST_RESULT;
		end else if (res_i.valid) begin
			if (RES_BITS == 24) begin
				held <= res_i.data;
			end else begin
				held <= {res_i.data[15:0], 8'h00};
			end
		end else begin
			if (byte_we_i[2]) begin
				held[23:16] <= wdata_i;
			end
			if (byte_we_i[1]) begin
				held[15:8] <= wdata_i;
			end
			if (byte_we_i[0] && RES_BITS == 24) begin
				held[7:0] <= wdata_i;
			end
		end
	end

	assign value_o = held;
endmodule : sdm_result_reg
`default_nettype wire

// [rtl/sdm_src_decode.sv]
`default_nettype none
`include "sdm_map.svh"
module sdm_src_decode (
	// select code
	input wire logic [3:0] code_i,
	// decoded source
	output sdm_pkg::sdm_src_t src_o
);
	always_comb begin
		src_o.pin = code_i[2:0];
		if (code_i[3] == 1'b0) begin
			src_o.kind = sdm_pkg::SDM_SRC_PIN;
		end else if (code_i == `SDM_SEL_TEMP) begin
			src_o.kind = sdm_pkg::SDM_SRC_TEMP;
		end else begin
			src_o.kind = sdm_pkg::SDM_SRC_GND;
		end
	end
endmodule : sdm_src_decode
`default_nettype wire

// [sim/sdm_cal_monitor.sv]
`default_nettype none
`include "sdm_map.svh"
module sdm_cal_monitor (
	// watched ports
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire sdm_pkg::sdm_sfr_req_t sfr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	input wire logic [2:0] converter_system_mode_i,
	input wire logic cal_ofs_we_i,
	input wire logic [23:0] cal_ofs_i,
	input wire logic cal_gain_we_i,
	input wire logic [23:0] cal_gain_i,
	input wire logic [23:0] offset_cal_value_o,
	input wire logic [23:0] gain_cal_value_o,
	input wire sdm_pkg::sdm_src_t positive_input_o,
	input wire sdm_pkg::sdm_src_t negative_input_o,
	input wire logic temp_sensor_en_o,
	input wire logic mux_write_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_temp_enable: assert property (sfr_i.wr && sfr_i.addr == `SDM_ADDR_MUX
		&& (sfr_i.wdata[7:4] == 4'hF || sfr_i.wdata[3:0] == 4'hF) |=> temp_sensor_en_o)
		else $error("temp enable missing");
	a_temp_disable: assert property (sfr_i.wr && sfr_i.addr == `SDM_ADDR_MUX
		&& sfr_i.wdata[7:4] != 4'hF && sfr_i.wdata[3:0] != 4'hF |=> !temp_sensor_en_o)
		else $error("temp enable stray");
	a_hit_after_rd: assert property (sfr_hit_o |-> $past(sfr_i.rd))
		else $error("hit without read");
	a_unmapped_quiet: assert property (sfr_i.rd && sfr_i.addr == 8'h00
		|=> !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("unmapped read answered");
	a_mux_read_hit: assert property (sfr_i.rd && sfr_i.addr == `SDM_ADDR_MUX |=> sfr_hit_o)
		else $error("mux read not hit");
	a_ofs_engine: assert property (cal_ofs_we_i |=> offset_cal_value_o == $past(cal_ofs_i))
		else $error("offset engine write lost");
	a_gain_engine: assert property (cal_gain_we_i |=> gain_cal_value_o == $past(cal_gain_i))
		else $error("gain engine write lost");
	a_ofs_hi_write: assert property (sfr_i.wr && sfr_i.addr == `SDM_ADDR_OFS_HI && !cal_ofs_we_i
		|=> offset_cal_value_o[23:16] == $past(sfr_i.wdata)) else $error("offset high write");
	a_ofs_hold: assert property (!cal_ofs_we_i && !sfr_i.wr |=> $stable(offset_cal_value_o))
		else $error("offset changed alone");
	a_busy_flag: assert property (sfr_i.wr && sfr_i.addr == `SDM_ADDR_MUX
		|=> mux_write_busy_o == ($past(converter_system_mode_i) != `SDM_MODE_IDLE))
		else $error("busy flag wrong");
endmodule : sdm_cal_monitor
`default_nettype wire

// [sim/sdm_cal_result_mux_tb.sv]
`default_nettype none
module sdm_cal_result_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'h0;
	logic rstn_i = 1'h0;
	sdm_pkg::sdm_sfr_req_t sfr_i = '0;
	logic [2:0] converter_system_mode_i = 3'h0;
	sdm_pkg::sdm_result_t sinc_res_i = '0;
	sdm_pkg::sdm_result_t fast_res_i = '0;
	logic cal_ofs_we_i = 1'h0;
	logic cal_gain_we_i = 1'h0;
	logic [23:0] cal_ofs_i = 24'h0;
	logic [23:0] cal_gain_i = 24'h0;
	logic [7:0] sfr_rdata_o, rd16;
	logic sfr_hit_o, temp_sensor_en_o, mux_write_busy_o;
	logic [23:0] offset_cal_value_o, gain_cal_value_o;
	sdm_pkg::sdm_src_t positive_input_o, negative_input_o;
	logic [7:0] ad [13] = '{8'hBA, 8'hBB, 8'hBC, 8'hAB, 8'hAC, 8'hAD,
		8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hFC, 8'hFD, 8'hFE};
	int fail_count = 0;
	int n_tests = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	sdm_cal_result_mux sdm_cal_result_mux_i (.*);
	// reduced variant shares every input, only its read data is observed
	sdm_cal_result_mux #(.RES_BITS(16)) sdm_cal_result_mux_r16_i (.*, .sfr_rdata_o(rd16),
		.sfr_hit_o(), .offset_cal_value_o(), .gain_cal_value_o(), .positive_input_o(),
		.negative_input_o(), .temp_sensor_en_o(), .mux_write_busy_o());
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_i.wr = 1'h1;
		sfr_i.addr = a;
		sfr_i.wdata = d;
		@(posedge sys_clk_i) #1;
		sfr_i.wr = 1'h0;
		@(posedge sys_clk_i) #1;
	endtask : wr
	task automatic rd(input logic [7:0] a, e24, e16, input logic h);
		sfr_i.rd = 1'h1;
		sfr_i.addr = a;
		@(posedge sys_clk_i) #1;
		sfr_i.rd = 1'h0;
		chk("rdata", e24, sfr_rdata_o);
		chk("rdata16", e16, rd16);
		chk("hit", h, sfr_hit_o);
		@(posedge sys_clk_i) #1;
	endtask : rd
	function automatic sdm_pkg::sdm_src_kind_t kd(input int c);
		return c < 8 ? sdm_pkg::SDM_SRC_PIN : c == 15 ? sdm_pkg::SDM_SRC_TEMP : sdm_pkg::SDM_SRC_GND;
	endfunction : kd
	task automatic report_and_stop;
		if (fail_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#20us;
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge sys_clk_i);
		#1 rstn_i = 1'h1;
		foreach (ad[i]) rd(ad[i], 8'h00, 8'h00, 1'h1);
		for (int i = 0; i < 6; i++) wr(ad[i], 8'(8'h11 * (i + 1)));
		for (int i = 0; i < 6; i++) rd(ad[i], 8'(8'h11 * (i + 1)), 8'(8'h11 * (i + 1)), 1'h1);
		chk("ofs", 24'h332211, offset_cal_value_o);
		chk("gain", 24'h665544, gain_cal_value_o);
		rd(8'h00, 8'h00, 8'h00, 1'h0);
		// engine write must win over a software write in the same cycle
		{cal_ofs_we_i, cal_gain_we_i, sfr_i.wr, sfr_i.addr, sfr_i.wdata} = {3'h7, 16'hBCAA};
		cal_ofs_i = 24'hABCDEF;
		cal_gain_i = 24'h123456;
		@(posedge sys_clk_i) #1;
		{cal_ofs_we_i, cal_gain_we_i, sfr_i.wr} = 3'h0;
		chk("ofs_eng", 24'hABCDEF, offset_cal_value_o);
		chk("gain_eng", 24'h123456, gain_cal_value_o);
		sinc_res_i = {1'h1, 24'hA5B6C7};
		fast_res_i = {1'h1, 24'h123456};
		@(posedge sys_clk_i) #1;
		sinc_res_i.valid = 1'h0;
		fast_res_i.valid = 1'h0;
		rd(8'hC5, 8'hA5, 8'hB6, 1'h1);
		rd(8'hC4, 8'hB6, 8'hC7, 1'h1);
		rd(8'hC3, 8'hC7, 8'h00, 1'h1);
		rd(8'hFE, 8'h12, 8'h34, 1'h1);
		rd(8'hFD, 8'h34, 8'h56, 1'h1);
		rd(8'hFC, 8'h56, 8'h00, 1'h1);
		wr(8'hFC, 8'hEE);
		rd(8'hFC, 8'hEE, 8'h00, 1'h1);
		for (int c = 0; c < 16; c++) begin
			wr(8'hC6, {4'(c), ~4'(c)});
			chk("pos", kd(c), positive_input_o.kind);
			chk("neg", kd(15 - c), negative_input_o.kind);
			if (c < 8) chk("pin", 24'(c), positive_input_o.pin);
			if (c > 7) chk("npin", 24'(15 - c), negative_input_o.pin);
			chk("temp", c == 0 || c == 15, temp_sensor_en_o);
			rd(8'hC6, {4'(c), ~4'(c)}, {4'(c), ~4'(c)}, 1'h1);
		end
		converter_system_mode_i = 3'h3;
		wr(8'hC6, 8'h08);
		chk("busy", 1'h1, mux_write_busy_o);
		chk("single", sdm_pkg::SDM_SRC_GND, negative_input_o.kind);
		converter_system_mode_i = 3'h0;
		wr(8'hC6, 8'h80);
		chk("idle", 1'h0, mux_write_busy_o);
		report_and_stop();
	end
endmodule : sdm_cal_result_mux_tb
bind sdm_cal_result_mux sdm_cal_monitor sdm_cal_monitor_i (.*);
`default_nettype wire
